// ### bench/psr_ctrl_model.sv
// Controller model making shift edges on the clock or hold line
`timescale 1ns/10ps
`default_nettype none
module psr_ctrl_model (
  // Clock and commands
  input  wire logic clk,
  input  wire logic go,
  input  wire logic use_hold,
  input  wire logic hold_lvl,
  // Lines into the register
  output logic      shift_clock,
  output logic      clock_gate_hold
);
  logic pulse_clk = 1'h0;
  logic pulse_hold = 1'h0;
  // One-cycle pulse per command, low between pulses
  always @(posedge clk) begin
    pulse_clk  <= go & ~use_hold;
    pulse_hold <= go & use_hold;
  end
  assign shift_clock     = pulse_clk;
  assign clock_gate_hold = pulse_hold | hold_lvl;
endmodule : psr_ctrl_model
`default_nettype wire

// ### bench/psr_shift_register_tb_top.sv
// Bench for the parallel-to-serial shift register
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  failures++; $display("wrong value %s exp %h got %h", n, e, a); end end
module psr_shift_register_tb_top;
  typedef struct {logic [7:0] p, f, e;} psr_row_s;
  logic clk = 1'h0, rstn = 1'h0, sel = 1'h1, fill = 1'h0, rdy = 1'h0;
  logic go = 1'h0, use_h = 1'h0, hold = 1'h0;
  logic [7:0] pin = 8'h00, exp_q;
  logic sclk, gate, q, qn, qa, bv, bd;
  logic q_bits [$];
  int failures = 0, num_checks = 0;
  psr_row_s rows [3] = '{'{8'ha5, 8'h01, 8'h80}, '{8'h3c, 8'hb2, 8'h4d},
                         '{8'hff, 8'h00, 8'h00}};
  always #2 clk = ~clk;
  psr_ctrl_model psr_ctrl_model_i (.clk(clk), .go(go), .use_hold(use_h),
    .hold_lvl(hold), .shift_clock(sclk), .clock_gate_hold(gate));
  psr_shift_register psr_shift_register_i (.clk(clk), .rstn(rstn),
    .load_shift_select(sel), .shift_clock(sclk), .clock_gate_hold(gate),
    .fill_bit_in(fill), .parallel_in(pin), .last_stage_out(q),
    .last_stage_out_n(qn), .first_stage_value(qa), .bit_valid(bv),
    .bit_data(bd), .bit_ready(rdy));
  task automatic chk_out(string n);
    `CHK(n, {exp_q[7], ~exp_q[7], exp_q[0]}, {q, qn, qa})
  endtask : chk_out
  task automatic load(input logic [7:0] p);
    @(posedge clk);
    sel <= 1'h0;
    pin <= p;
    @(posedge clk);
    sel <= 1'h1;
    #1;
    exp_q = p;
    chk_out("load");
  endtask : load
  task automatic shift(input logic f, input logic h, input logic drop);
    @(posedge clk);
    fill <= f;
    go <= 1'h1;
    use_h <= h;
    @(posedge clk);
    go <= 1'h0;
    @(posedge clk);
    #1;
    if (!drop) begin
      q_bits.push_back(exp_q[7]);
      exp_q = {exp_q[6:0], f};
    end
    chk_out("shift");
  endtask : shift
  task automatic drain();
    logic e;
    @(posedge clk);
    rdy <= 1'h1;
    repeat (40) begin
      @(negedge clk);
      if (q_bits.size() == 0) `CHK("fifo_idle", 1'h0, bv)
      else if (bv === 1'h1) begin
        e = q_bits.pop_front();
        `CHK("fifo_bit", e, bd)
      end
    end
    if (q_bits.size() != 0) failures++;
    @(posedge clk);
    rdy <= 1'h0;
  endtask : drain
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    @(posedge clk);
    #1;
    `CHK("reset", 4'h4, {q, qn, qa, bv})
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      load(rows[i].p);
      for (int k = 0; k < 8; k++) shift(rows[i].f[k], k[0], 1'h0);
      `CHK("row", {rows[i].e[7], rows[i].e[0]}, {q, qa})
      drain();
      $display("row test %0d done", i);
    end
    @(posedge clk);
    sel <= 1'h0;
    pin <= 8'hc3;
    go <= 1'h1;
    use_h <= 1'h0;
    @(posedge clk);
    sel <= 1'h1;
    go <= 1'h0;
    @(posedge clk);
    #1;
    q_bits.push_back(1'h1);
    exp_q = 8'h86;
    chk_out("fast_shift");
    drain();
    $display("fast test done");
    @(posedge clk);
    sel <= 1'h0;
    hold <= 1'h1;
    load(8'h5a);
    shift(1'h1, 1'h0, 1'h1);
    @(posedge clk);
    pin <= 8'ha5;
    hold <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk_out("hold_release");
    $display("hold test done");
    for (int k = 0; k < 32; k++) shift(1'h1, 1'h0, 1'h0);
    shift(1'h0, 1'h0, 1'h1);
    drain();
    $display("full test done");
    results();
  end
endmodule : psr_shift_register_tb_top
`default_nettype wire

// ### design/psr_pkg.sv
// Constants shared by the parallel-to-serial shift register block
//
// Overview of operation
// [R1] Eight stages, each with its own parallel input used while select is low.
// [R2] Select low copies parallel input bit i into stage i.
// [R3] Loading is continuous and ignores shift clock, hold and fill bit.
// [R4] Select high ignores the parallel inputs; no load happens.
// [R5] Shift on shift clock rise with select high, hold low; else keep; the code drops the rise without a shift while the FIFO is full.
// [R6] A hold rise while shift clock is low also makes one shift; the code drops this rise too while the FIFO is full.
// [R7] Controller should raise hold only while the shift clock is high; the bench controller raises it while the clock is low.
// [R8] Each shift moves data toward the output; fill bit enters stage one.
// [R9] Last stage shows on a true output and an inverted output.
package psr_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int          PSR_STAGES     = 8;
  localparam int          PSR_FIFO_DEPTH = 32;
  localparam int          PSR_FIFO_WIDTH = 1;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  PSR_STAGE_RST  = 8'h00;
  localparam logic        PSR_GATE_RST   = 1'h1;

endpackage : psr_pkg

// ### design/psr_shift_register.sv
// Parallel-in serial-out shift register with a drain FIFO
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// FIFO with registered output stage
// ------------------------------------------------------------------
module psr_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;

  wire              push      = in_valid && in_ready;
  wire              pop       = (count != '0) && (!out_valid || out_ready);
  wire [AW-1:0]     next_wr   = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0]     next_rd   = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
  wire [CW-1:0]     next_count = count + CW'(push) - CW'(pop);

  // Output stage counts too, so no more than DEPTH bits wait at once
  wire [CW-1:0]     occupancy  = count + CW'(out_valid);

  assign in_ready = (occupancy != FULL);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? next_wr : wr_ptr;
      rd_ptr <= pop ? next_rd : rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Buffer assertions
  // ------------------------------------------------------------------
  fifo_room_a: assert property ( // R8
    @(posedge clk) disable iff (!rstn)
    occupancy <= FULL)
    else $error("buffer holds more than its depth");

  fifo_hold_a: assert property ( // R8
    @(posedge clk) disable iff (!rstn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head changed before it was taken");

endmodule : psr_fifo

// ------------------------------------------------------------------
// Shift register top
// ------------------------------------------------------------------
module psr_shift_register
  import psr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control inputs
  input  wire logic       load_shift_select,
  input  wire logic       shift_clock,
  input  wire logic       clock_gate_hold,
  input  wire logic       fill_bit_in,
  // Parallel data, bit 0 feeds the first stage
  input  wire logic [7:0] parallel_in,
  // Serial outputs
  output logic            last_stage_out,
  output logic            last_stage_out_n,
  output logic            first_stage_value,
  // Stream of bits leaving the last stage
  output logic            bit_valid,
  output logic            bit_data,
  input  wire logic       bit_ready
);

  function automatic logic [7:0] psr_shift(input logic [7:0] cur,
                                           input logic       fill);
    psr_shift = {cur[6:0], fill};
  endfunction : psr_shift

  logic [7:0] stages;
  logic       gated_q;
  logic       fifo_ready;

  // Clock and hold are ORed, so either one rising while the other is low makes the edge
  wire        gated      = shift_clock | clock_gate_hold; // R5 R6
  wire        gated_rise = gated & ~gated_q;
  wire        load_en    = ~load_shift_select; // R3 R4
  wire        shift_req  = load_shift_select & gated_rise; // R5 R6
  // A full FIFO blocks the shift and the edge is dropped, so no bit is lost
  wire        shift_en   = shift_req & fifo_ready;
  wire [7:0]  next_stages = load_en  ? parallel_in : // R1 R2
                            shift_en ? psr_shift(stages, fill_bit_in) : // R8
                            stages;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stages  <= PSR_STAGE_RST;
      gated_q <= PSR_GATE_RST;
    end else begin
      stages  <= next_stages;
      gated_q <= gated;
    end
  end

  // Outputs mirror the stage flops, taken from the same next value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_stage_out    <= PSR_STAGE_RST[7];
      last_stage_out_n  <= ~PSR_STAGE_RST[7];
      first_stage_value <= PSR_STAGE_RST[0];
    end else begin
      last_stage_out    <= next_stages[7]; // R9
      last_stage_out_n  <= ~next_stages[7]; // R9
      first_stage_value <= next_stages[0];
    end
  end

  psr_fifo #(
    .WIDTH (PSR_FIFO_WIDTH),
    .DEPTH (PSR_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (shift_en),
    .in_data   (stages[7]),
    .in_ready  (fifo_ready),
    .out_valid (bit_valid),
    .out_data  (bit_data),
    .out_ready (bit_ready)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_load_then_shift;
    !load_shift_select ##1 (load_shift_select && shift_en);
  endsequence

  sequence s_clock_rise_alone;
    load_shift_select && shift_clock && !$past(shift_clock) &&
    !clock_gate_hold && !$past(clock_gate_hold) && fifo_ready;
  endsequence

  sequence s_hold_rise_alone;
    load_shift_select && clock_gate_hold && !$past(clock_gate_hold) &&
    !shift_clock && !$past(shift_clock) && fifo_ready;
  endsequence

  stage_count_a: assert property ( // R1
    s_load_then_shift |=> last_stage_out == $past(parallel_in[6], 2))
    else $error("second bit of a loaded byte not in last stage");

  load_copy_a: assert property ( // R2
    !load_shift_select |=> stages == $past(parallel_in))
    else $error("parallel load did not copy inputs");

  load_indep_a: assert property ( // R3
    !load_shift_select && $changed(shift_clock) |=>
      first_stage_value == $past(parallel_in[0]) && !$past(shift_en))
    else $error("load disturbed by shift clock");

  no_load_a: assert property ( // R4
    load_shift_select && !shift_en |=> $stable(stages))
    else $error("stages changed without a shift");

  hold_keep_a: assert property ( // R5
    load_shift_select && clock_gate_hold && $past(clock_gate_hold) |=>
      $stable(stages))
    else $error("stages moved while hold high");

  clock_shift_a: assert property ( // R5
    s_clock_rise_alone |=> stages == $past({stages[6:0], fill_bit_in}))
    else $error("clock rise did not shift");

  hold_shift_a: assert property ( // R6
    s_hold_rise_alone |=> stages == $past({stages[6:0], fill_bit_in}))
    else $error("hold rise did not shift");

  shift_move_a: assert property ( // R8
    shift_en ##1 (load_shift_select && !shift_en)[*2] |->
      stages[7:1] == $past(stages[6:0], 2))
    else $error("shift did not move stages");

  serial_out_a: assert property ( // R9
    last_stage_out == stages[7] && last_stage_out_n == !last_stage_out)
    else $error("serial outputs wrong");

  sequence s_gate_rise;
    load_shift_select && gated_rise && fifo_ready;
  endsequence

  sequence s_shift_stall;
    shift_req && !fifo_ready;
  endsequence

  fill_enter_a: assert property ( // R8
    shift_en |=> stages[0] == $past(fill_bit_in))
    else $error("fill bit did not enter first stage");

  stage_step_a: assert property ( // R8
    shift_en |=> stages[7:1] == $past(stages[6:0]))
    else $error("stages did not step toward output");

  load_last_a: assert property ( // R2
    !load_shift_select |=> last_stage_out == $past(parallel_in[7]))
    else $error("last stage not loaded from top input");

  load_first_a: assert property ( // R2
    !load_shift_select |=> first_stage_value == $past(parallel_in[0]))
    else $error("first stage not loaded from bottom input");

  load_fill_a: assert property ( // R3
    !load_shift_select && $changed(fill_bit_in) |=>
      stages == $past(parallel_in))
    else $error("load disturbed by fill bit");

  hold_high_a: assert property ( // R5
    clock_gate_hold && $past(clock_gate_hold) |-> !shift_en)
    else $error("shift while hold stayed high");

  idle_low_a: assert property ( // R5
    !shift_clock && !clock_gate_hold |-> !shift_en)
    else $error("shift with clock and hold both low");

  rise_shift_a: assert property ( // R6
    s_gate_rise |-> shift_en)
    else $error("gate rise with room did not shift");

  full_stall_a: assert property ( // R5
    s_shift_stall |=> $stable(stages))
    else $error("stages moved while buffer full");

  first_mirror_a: assert property ( // R8
    first_stage_value == stages[0])
    else $error("first stage output wrong");

  select_high_a: assert property ( // R4
    load_shift_select && $changed(parallel_in) && !shift_en |=>
      $stable(stages))
    else $error("parallel inputs used while select high");

endmodule : psr_shift_register

`default_nettype wire
